// File: shared/cgf_defines.svh
// Register offsets, field positions and reset values for the clock flag block.
// Assumes a byte-wide register port addressed by the offsets below.
`ifndef CGF_DEFINES_SVH
`define CGF_DEFINES_SVH

`define CGF_ADDR_W          8
`define CGF_OFS_FLAGS       8'h03
`define CGF_OFS_IRQ_EN      8'h04
`define CGF_OFS_CTRL        8'h08
`define CGF_OFS_STATUS      8'h0C
`define CGF_OFS_CLEAR       8'h0D
`define CGF_OFS_EVT_EN      8'h0E

`define CGF_BIT_TICK        7
`define CGF_BIT_LOCK_FLAG   4
`define CGF_BIT_LOSS_FLAG   1
`define CGF_BIT_SELF_STAT   0

`define CGF_BIT_CME         0
`define CGF_BIT_FALLBACK_CLOCK_EN        1
`define CGF_BIT_PLL_CLOCK_SELECT      2

`define CGF_EVT_ENTER       0
`define CGF_EVT_LEAVE       1

`define CGF_RST_BYTE        8'h00
`define CGF_RST_CTRL        3'h3

`endif

// File: shared/cgf_pkg.sv
// Types shared by the clock flag block.
// Assumes cgf_defines.svh sits in the include path.
package cgf_pkg;
	typedef logic [7:0] cgf_byte_t;
	typedef enum logic [1:0]
	{
		CGF_NORMAL = 2'b01,
		CGF_SELF   = 2'b10
	} cgf_mode_e;
endpackage

// File: logic/cgf_clock_flags.sv
// Flag, interrupt enable and self-clock fallback logic of a clock generator.
// Assumes a synchronous register port and oscillator status inputs in this clock domain.
//
// Overview of operation
// R1: Self-clock change flag sets whenever the self-clock status bit toggles.
// R2: Change flag clears only on writing one; writing zero keeps it.
// R3: Set change flag with its enable high raises an interrupt request.
// R4: Status bit 0 is read-only: zero on oscillator, one in self-clock.
// R5: Writes to the self-clock status bit never change it.
// R6: Enable register at 0x0004 is read/write; bit 7 enables tick interrupts.
// R7: Enable bit 4 gates lock change flag onto the interrupt request.
// R8: Enable bit 1 gates self-clock change flag; zero suppresses it.
// R9: Without an oscillator clock, clocks come from PLL at minimum frequency.
// R10: Self-clock mode entered only when monitor and fallback enables are one.
// R11: Entering self-clock mode clears the PLL clock select bit.
// R12: A stable oscillator returns the system clock to it automatically.
// R13: Interrupt requests hold until flag clears or enable drops.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cgf_defines.svh"

module cgf_clock_flags
	import cgf_pkg::*;
(
	input  wire logic                   clock_i,         // 100 MHz clock
	input  wire logic                   srst_i,          // Synchronous reset, high
	input  wire logic [`CGF_ADDR_W-1:0] addr_i,          // Register address
	input  wire cgf_pkg::cgf_byte_t     wdata_i,         // Write data
	input  wire logic                   wr_i,            // Write strobe
	input  wire logic                   rd_i,            // Read strobe
	input  wire logic                   osc_ok_i,        // Oscillator clock stable
	input  wire logic                   tick_event_i,    // Periodic tick event pulse
	input  wire logic                   lock_event_i,    // PLL lock change event pulse
	output logic [7:0]                  rdata_o,         // Read data, cycle after read
	output logic                        crg_irq_o,       // Combined flag interrupt
	output logic                        evt_irq_o,       // Mode event interrupt
	output logic                        self_clock_o,    // Running on fallback clock
	output logic                        pll_clock_select_o, // PLL drives system clock
	output logic                        fallback_clk_sel_o  // Bus clock from PLL minimum
);
	import cgf_pkg::*;

	typedef struct packed
	{
		cgf_mode_e  mode;
		logic       tick_flag;
		logic       lock_flag;
		logic       loss_flag;
		cgf_byte_t  irq_en;
		logic [2:0] ctrl;
		logic [1:0] evt_stat;
		logic [1:0] evt_en;
		cgf_byte_t  rdata;
		logic       crg_irq;
		logic       evt_irq;
		logic       self_clk;
	} cgf_state_s;

	cgf_state_s st_reg;
	cgf_state_s st_next;

	function automatic logic hit(input logic [`CGF_ADDR_W-1:0] a,
		input logic [`CGF_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	logic self_now;
	logic wr_flags;
	logic wr_irq_en;
	logic wr_ctrl;
	logic wr_clear;
	logic wr_evt_en;
	logic go_self;
	logic go_norm;

	assign self_now  = (st_reg.mode == CGF_SELF);
	assign wr_flags  = wr_i && hit(addr_i, `CGF_OFS_FLAGS);
	assign wr_irq_en = wr_i && hit(addr_i, `CGF_OFS_IRQ_EN);
	assign wr_ctrl   = wr_i && hit(addr_i, `CGF_OFS_CTRL);
	assign wr_clear  = wr_i && hit(addr_i, `CGF_OFS_CLEAR);
	assign wr_evt_en = wr_i && hit(addr_i, `CGF_OFS_EVT_EN);

	// Fallback needs both the monitor and fallback enables
	assign go_self = !self_now && !osc_ok_i
		&& st_reg.ctrl[`CGF_BIT_CME] && st_reg.ctrl[`CGF_BIT_FALLBACK_CLOCK_EN]; // see R9 see R10
	assign go_norm = self_now && osc_ok_i; // see R12

	always_comb
	begin
		st_next = st_reg;

		// Mode machine; status bit follows it and ignores writes
		case (st_reg.mode)
			CGF_NORMAL:
			begin
				if (go_self)
				begin
					st_next.mode = CGF_SELF; // see R4 see R5
				end
			end
			CGF_SELF:
			begin
				if (go_norm)
				begin
					st_next.mode = CGF_NORMAL; // see R12
				end
			end
			default:
			begin
				st_next.mode = CGF_NORMAL;
			end
		endcase

		// Writes of one clear; a same-cycle event wins
		if (wr_flags)
		begin
			if (wdata_i[`CGF_BIT_TICK])
			begin
				st_next.tick_flag = 1'b0;
			end
			if (wdata_i[`CGF_BIT_LOCK_FLAG])
			begin
				st_next.lock_flag = 1'b0;
			end
			if (wdata_i[`CGF_BIT_LOSS_FLAG])
			begin
				st_next.loss_flag = 1'b0; // see R2
			end
		end
		if (tick_event_i)
		begin
			st_next.tick_flag = 1'b1;
		end
		if (lock_event_i)
		begin
			st_next.lock_flag = 1'b1;
		end
		if (go_self || go_norm)
		begin
			st_next.loss_flag = 1'b1; // see R1
		end

		if (wr_irq_en)
		begin
			st_next.irq_en = wdata_i; // see R6
		end
		if (wr_ctrl)
		begin
			st_next.ctrl = wdata_i[2:0];
		end
		// Hardware clear beats software setting of PLL select
		if (go_self)
		begin
			st_next.ctrl[`CGF_BIT_PLL_CLOCK_SELECT] = 1'b0; // see R11
		end

		if (wr_clear)
		begin
			st_next.evt_stat = st_next.evt_stat & ~wdata_i[1:0];
		end
		if (wr_evt_en)
		begin
			st_next.evt_en = wdata_i[1:0];
		end
		if (go_self)
		begin
			st_next.evt_stat[`CGF_EVT_ENTER] = 1'b1;
		end
		if (go_norm)
		begin
			st_next.evt_stat[`CGF_EVT_LEAVE] = 1'b1;
		end

		st_next.crg_irq =
			(st_next.tick_flag && st_next.irq_en[`CGF_BIT_TICK])          // see R6
			|| (st_next.lock_flag && st_next.irq_en[`CGF_BIT_LOCK_FLAG]) // see R7
			|| (st_next.loss_flag && st_next.irq_en[`CGF_BIT_LOSS_FLAG]); // see R3 see R8 see R13
		st_next.evt_irq = |(st_next.evt_stat & st_next.evt_en);

		st_next.rdata = `CGF_RST_BYTE;
		if (rd_i)
		begin
			if (hit(addr_i, `CGF_OFS_FLAGS))
			begin
				st_next.rdata[`CGF_BIT_TICK]      = st_reg.tick_flag;
				st_next.rdata[`CGF_BIT_LOCK_FLAG] = st_reg.lock_flag;
				st_next.rdata[`CGF_BIT_LOSS_FLAG] = st_reg.loss_flag;
				st_next.rdata[`CGF_BIT_SELF_STAT] = self_now; // see R4
			end
			else if (hit(addr_i, `CGF_OFS_IRQ_EN))
			begin
				st_next.rdata = st_reg.irq_en; // see R6
			end
			else if (hit(addr_i, `CGF_OFS_CTRL))
			begin
				st_next.rdata[2:0] = st_reg.ctrl;
			end
			else if (hit(addr_i, `CGF_OFS_STATUS))
			begin
				st_next.rdata[1:0] = st_reg.evt_stat;
			end
			else if (hit(addr_i, `CGF_OFS_EVT_EN))
			begin
				st_next.rdata[1:0] = st_reg.evt_en;
			end
		end

		if (srst_i)
		begin
			st_next           = '0;
			st_next.mode      = CGF_NORMAL;
			st_next.irq_en    = `CGF_RST_BYTE;
			st_next.ctrl      = `CGF_RST_CTRL;
		end

		// Registered copy so the mode outputs leave straight from a flop
		st_next.self_clk = (st_next.mode == CGF_SELF);
	end

	always_ff @(posedge clock_i)
	begin
		st_reg <= st_next;
	end

	assign rdata_o            = st_reg.rdata;
	assign crg_irq_o          = st_reg.crg_irq;
	assign evt_irq_o          = st_reg.evt_irq;
	assign self_clock_o       = st_reg.self_clk;
	assign pll_clock_select_o = st_reg.ctrl[`CGF_BIT_PLL_CLOCK_SELECT];
	assign fallback_clk_sel_o = st_reg.self_clk; // see R9

	a_loss_flag_set: assert property (@(posedge clock_i) disable iff (srst_i) // see R1
		$changed(self_now) |-> st_reg.loss_flag)
		else $error("change flag not set on mode change");

	a_loss_zero_write: assert property (@(posedge clock_i) disable iff (srst_i) // see R2
		(st_reg.loss_flag && wr_flags && !wdata_i[`CGF_BIT_LOSS_FLAG]) |=> st_reg.loss_flag)
		else $error("change flag lost on zero write");

	a_loss_one_write: assert property (@(posedge clock_i) disable iff (srst_i) // see R2
		(wr_flags && wdata_i[`CGF_BIT_LOSS_FLAG] && !go_self && !go_norm)
		|=> !st_reg.loss_flag)
		else $error("change flag not cleared by one");

	a_loss_irq_gate: assert property (@(posedge clock_i) disable iff (srst_i) // see R3
		(st_reg.loss_flag && st_reg.irq_en[`CGF_BIT_LOSS_FLAG]) |-> crg_irq_o)
		else $error("change interrupt missing");

	a_irq_no_source: assert property (@(posedge clock_i) disable iff (srst_i) // see R8
		(crg_irq_o && !(st_reg.tick_flag && st_reg.irq_en[`CGF_BIT_TICK])
		&& !(st_reg.lock_flag && st_reg.irq_en[`CGF_BIT_LOCK_FLAG]))
		|-> (st_reg.loss_flag && st_reg.irq_en[`CGF_BIT_LOSS_FLAG]))
		else $error("interrupt without enabled source");

	a_lock_irq_gate: assert property (@(posedge clock_i) disable iff (srst_i) // see R7
		(st_reg.lock_flag && st_reg.irq_en[`CGF_BIT_LOCK_FLAG]) |-> crg_irq_o)
		else $error("lock interrupt missing");

	a_en_readback: assert property (@(posedge clock_i) disable iff (srst_i) // see R6
		wr_irq_en ##1 (rd_i && hit(addr_i, `CGF_OFS_IRQ_EN) && !wr_i)
		|=> (rdata_o == $past(wdata_i, 2)))
		else $error("enable register readback wrong");

	a_self_guard: assert property (@(posedge clock_i) disable iff (srst_i) // see R10
		$rose(self_now) |-> $past(st_reg.ctrl[`CGF_BIT_CME] && st_reg.ctrl[`CGF_BIT_FALLBACK_CLOCK_EN]))
		else $error("self-clock entered without enables");

	a_pll_cleared: assert property (@(posedge clock_i) disable iff (srst_i) // see R11
		$rose(self_now) |-> !pll_clock_select_o)
		else $error("PLL select kept on fallback");

	a_auto_return: assert property (@(posedge clock_i) disable iff (srst_i) // see R12
		(self_now && osc_ok_i) |=> !self_now)
		else $error("no return to oscillator clock");

	a_status_read: assert property (@(posedge clock_i) disable iff (srst_i) // see R4 see R5
		(rd_i && hit(addr_i, `CGF_OFS_FLAGS)) |=> (rdata_o[`CGF_BIT_SELF_STAT] == $past(self_now)))
		else $error("status bit readback wrong");

	// Flag setting, gating and mode holding; a mode change shows one cycle after go_self
	// Set beats a same-cycle clear, so the set checks ignore write traffic
	a_tick_flag_set: assert property (@(posedge clock_i) disable iff (srst_i) // see R6
		tick_event_i |=> st_reg.tick_flag)
		else $error("tick flag not set by event");

	a_lock_flag_set: assert property (@(posedge clock_i) disable iff (srst_i) // see R7
		lock_event_i |=> st_reg.lock_flag)
		else $error("lock flag not set by event");

	a_tick_irq_gate: assert property (@(posedge clock_i) disable iff (srst_i) // see R6
		(st_reg.tick_flag && st_reg.irq_en[`CGF_BIT_TICK]) |-> crg_irq_o)
		else $error("tick interrupt missing");

	a_tick_clear: assert property (@(posedge clock_i) disable iff (srst_i) // see R13
		(wr_flags && wdata_i[`CGF_BIT_TICK] && !tick_event_i) |=> !st_reg.tick_flag)
		else $error("tick flag not cleared by one");

	a_irq_cleared: assert property (@(posedge clock_i) disable iff (srst_i) // see R13
		(!st_reg.tick_flag && !st_reg.lock_flag && !st_reg.loss_flag) |-> !crg_irq_o)
		else $error("interrupt without any flag");

	a_loss_irq_off: assert property (@(posedge clock_i) disable iff (srst_i) // see R8
		(!st_reg.irq_en[`CGF_BIT_LOSS_FLAG] && !st_reg.tick_flag && !st_reg.lock_flag)
		|-> !crg_irq_o)
		else $error("masked change flag raised interrupt");

	a_loss_sticky: assert property (@(posedge clock_i) disable iff (srst_i) // see R2
		(st_reg.loss_flag && !wr_flags) |=> st_reg.loss_flag)
		else $error("change flag dropped without write");

	a_status_no_write: assert property (@(posedge clock_i) disable iff (srst_i) // see R5
		(wr_flags && !go_self && !go_norm) |=> $stable(self_now))
		else $error("status bit moved by write");

	a_self_output: assert property (@(posedge clock_i) disable iff (srst_i) // see R4
		self_clock_o == self_now)
		else $error("self-clock output off mode");

	a_fallback_select: assert property (@(posedge clock_i) disable iff (srst_i) // see R9
		fallback_clk_sel_o == self_now)
		else $error("fallback select off mode");

	a_self_stays: assert property (@(posedge clock_i) disable iff (srst_i) // see R9
		(self_now && !osc_ok_i) |=> self_now)
		else $error("left fallback without oscillator");

	a_norm_stays: assert property (@(posedge clock_i) disable iff (srst_i) // see R9
		(!self_now && osc_ok_i) |=> !self_now)
		else $error("fallback entered with oscillator");

	a_no_self_entry: assert property (@(posedge clock_i) disable iff (srst_i) // see R10
		(!self_now && !(st_reg.ctrl[`CGF_BIT_CME] && st_reg.ctrl[`CGF_BIT_FALLBACK_CLOCK_EN])) |=> !self_now)
		else $error("fallback entered while disabled");

	a_en_write: assert property (@(posedge clock_i) disable iff (srst_i) // see R6
		wr_irq_en |=> (st_reg.irq_en == $past(wdata_i)))
		else $error("enable register write lost");

	// Read data stand one cycle only, so a late sampler sees zero
	a_rdata_idle: assert property (@(posedge clock_i) disable iff (srst_i) // see R6
		!rd_i |=> (rdata_o == `CGF_RST_BYTE))
		else $error("read data not idle");
endmodule

`default_nettype wire

// File: verification/tb_cgf_clock_flags.sv
// Self-checking bench for the clock flag block: register port, flags, mode fallback.
// Assumes cgf_pkg is compiled first and cgf_defines.svh is in the include path.
`timescale 1ns/1ps
`default_nettype none
`include "cgf_defines.svh"

module tb_cgf_clock_flags;
	import cgf_pkg::*;

	logic       clock_i      = 1'b0;
	logic       srst_i       = 1'b1;
	logic [7:0] addr_i       = 8'h00;
	cgf_byte_t  wdata_i      = 8'h00;
	logic       wr_i         = 1'b0;
	logic       rd_i         = 1'b0;
	logic       osc_ok_i     = 1'b1;
	logic       tick_event_i = 1'b0;
	logic       lock_event_i = 1'b0;
	logic [7:0] rdata_o;
	logic       crg_irq_o;
	logic       evt_irq_o;
	logic       self_clock_o;
	logic       pll_clock_select_o;
	logic       fallback_clk_sel_o;
	int         n_fail       = 0;
	int         n_compared   = 0;

	always #5 clock_i = ~clock_i;

	cgf_clock_flags dut (
		.clock_i            (clock_i),
		.srst_i             (srst_i),
		.addr_i             (addr_i),
		.wdata_i            (wdata_i),
		.wr_i               (wr_i),
		.rd_i               (rd_i),
		.osc_ok_i           (osc_ok_i),
		.tick_event_i       (tick_event_i),
		.lock_event_i       (lock_event_i),
		.rdata_o            (rdata_o),
		.crg_irq_o          (crg_irq_o),
		.evt_irq_o          (evt_irq_o),
		.self_clock_o       (self_clock_o),
		.pll_clock_select_o (pll_clock_select_o),
		.fallback_clk_sel_o (fallback_clk_sel_o)
	);

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Order: crg irq, event irq, self clock, fallback select, pll select
	task automatic ck_out(input logic [4:0] exp);
		chk({3'h0, crg_irq_o, evt_irq_o, self_clock_o, fallback_clk_sel_o,
			pll_clock_select_o}, {3'h0, exp});
	endtask

	// Settling cycles after each write let registered irq levels follow
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	// Write then read back with no gap between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, d);
	endtask

	task automatic pulse(input logic lock);
		@(posedge clock_i);
		tick_event_i <= ~lock;
		lock_event_i <= lock;
		@(posedge clock_i);
		tick_event_i <= 1'b0;
		lock_event_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
	endtask

	task automatic osc(input logic v);
		@(posedge clock_i);
		osc_ok_i <= v;
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	initial
	begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial
	begin
		repeat (6) @(posedge clock_i);
		srst_i <= 1'b0;
		#1;
		ck_out(5'h00);
		rd(`CGF_OFS_IRQ_EN, 8'h00);
		rd(`CGF_OFS_FLAGS, 8'h00);
		rd(`CGF_OFS_CTRL, 8'h03);
		rd(8'h20, 8'h00);
		wr(`CGF_OFS_IRQ_EN, 8'h92);
		rd(`CGF_OFS_IRQ_EN, 8'h92);
		wr_rd(`CGF_OFS_IRQ_EN, 8'h6D);
		wr(`CGF_OFS_IRQ_EN, 8'h80);
		pulse(1'b0);
		rd(`CGF_OFS_FLAGS, 8'h80);
		ck_out(5'h10);
		wr(`CGF_OFS_IRQ_EN, 8'h00);
		ck_out(5'h00);
		wr(`CGF_OFS_IRQ_EN, 8'h80);
		ck_out(5'h10);
		wr(`CGF_OFS_FLAGS, 8'h80);
		ck_out(5'h00);
		wr(`CGF_OFS_IRQ_EN, 8'h00);
		pulse(1'b1);
		ck_out(5'h00);
		wr(`CGF_OFS_IRQ_EN, 8'h10);
		ck_out(5'h10);
		wr(`CGF_OFS_FLAGS, 8'h10);
		rd(`CGF_OFS_FLAGS, 8'h00);
		// Loss of oscillator with one enable missing must not fall back
		wr(`CGF_OFS_CTRL, 8'h01);
		osc(1'b0);
		ck_out(5'h00);
		wr(`CGF_OFS_CTRL, 8'h02);
		ck_out(5'h00);
		rd(`CGF_OFS_FLAGS, 8'h00);
		osc(1'b1);
		wr(`CGF_OFS_IRQ_EN, 8'h02);
		wr(`CGF_OFS_CTRL, 8'h07);
		ck_out(5'h01);
		osc(1'b0);
		ck_out(5'h16);
		rd(`CGF_OFS_FLAGS, 8'h03);
		wr(`CGF_OFS_FLAGS, 8'h01);
		rd(`CGF_OFS_FLAGS, 8'h03);
		wr(`CGF_OFS_FLAGS, 8'h02);
		rd(`CGF_OFS_FLAGS, 8'h01);
		ck_out(5'h06);
		wr(`CGF_OFS_IRQ_EN, 8'h00);
		osc(1'b1);
		ck_out(5'h00);
		rd(`CGF_OFS_FLAGS, 8'h02);
		wr(`CGF_OFS_IRQ_EN, 8'h02);
		ck_out(5'h10);
		rd(`CGF_OFS_STATUS, 8'h03);
		wr(`CGF_OFS_EVT_EN, 8'h01);
		ck_out(5'h18);
		rd(`CGF_OFS_EVT_EN, 8'h01);
		wr(`CGF_OFS_CLEAR, 8'h03);
		ck_out(5'h10);
		rd(`CGF_OFS_STATUS, 8'h00);
		wr(`CGF_OFS_FLAGS, 8'h02);
		ck_out(5'h00);
		// Mid-run reset must restore enables and drop PLL select
		wr(`CGF_OFS_CTRL, 8'h04);
		ck_out(5'h01);
		@(posedge clock_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		srst_i <= 1'b0;
		#1;
		ck_out(5'h00);
		rd(`CGF_OFS_CTRL, 8'h03);
		rd(`CGF_OFS_IRQ_EN, 8'h00);
		end_sim();
	end
endmodule

`default_nettype wire
